// *** logic/dcc_pkg.sv ***
// Register map, field positions and reset values of the comparator block
`default_nettype none
package dcc_pkg;
  localparam logic [11:0] DCC_ADDR_CTRL0  = 12'h000;
  localparam logic [11:0] DCC_ADDR_MUX0   = 12'h004;
  localparam logic [11:0] DCC_ADDR_MODE0  = 12'h008;
  localparam logic [11:0] DCC_ADDR_CTRL1  = 12'h010;
  localparam logic [11:0] DCC_ADDR_MUX1   = 12'h014;
  localparam logic [11:0] DCC_ADDR_MODE1  = 12'h018;
  localparam logic [11:0] DCC_ADDR_RSTSRC = 12'h020;
  localparam logic [11:0] DCC_CMP_STRIDE  = 12'h010;
  // Control register fields
  localparam int DCC_CTL_ON     = 7;
  localparam int DCC_CTL_RESULT = 6;
  localparam int DCC_CTL_RISE   = 5;
  localparam int DCC_CTL_FALL   = 4;
  localparam int DCC_CTL_HYP_LO = 2;
  localparam int DCC_CTL_HYN_LO = 0;
  // Mode register fields
  localparam int DCC_MD_RIE     = 5;
  localparam int DCC_MD_FIE     = 4;
  localparam int DCC_MD_RESP_LO = 0;
  // Mux register fields
  localparam int DCC_MX_NEG_LO  = 4;
  localparam int DCC_MX_POS_LO  = 0;
  // Reset values
  localparam logic [7:0] DCC_CTRL_RST = 8'h00;
  localparam logic [7:0] DCC_MUX_RST  = 8'hFF;
  localparam logic [1:0] DCC_RESP_RST = 2'h2;
  localparam logic [1:0] DCC_FIELD_RST = 2'h3;
  // Hysteresis codes: off, 5 mV, 10 mV, 20 mV
  typedef enum logic [1:0] {
    DCC_HYS_OFF  = 2'b00,
    DCC_HYS_5MV  = 2'b01,
    DCC_HYS_10MV = 2'b10,
    DCC_HYS_20MV = 2'b11
  } dcc_hys_t;
endpackage : dcc_pkg
`default_nettype wire

// *** logic/dcc_top.sv ***
// Two-comparator control, status and edge-flag logic behind an APB slave
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`default_nettype none
module dcc_top
  import dcc_pkg::*;
(
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  // Analog comparator cores
  input  wire logic        cmp_zero_core_out,
  input  wire logic        cmp_one_core_out,
  output logic             cmp_zero_on,
  output logic             cmp_one_on,
  output logic       [1:0] cmp_zero_pos_select,
  output logic       [1:0] cmp_zero_neg_select,
  output logic       [1:0] cmp_one_pos_select,
  output logic       [1:0] cmp_one_neg_select,
  output logic       [1:0] cmp_zero_pos_hysteresis,
  output logic       [1:0] cmp_zero_neg_hysteresis,
  output logic       [1:0] cmp_one_pos_hysteresis,
  output logic       [1:0] cmp_one_neg_hysteresis,
  output logic       [1:0] cmp_zero_response_select,
  output logic       [1:0] cmp_one_response_select,
  // Toward crossbar, reset and interrupt logic
  output logic             cmp_zero_latched_out,
  output logic             cmp_one_latched_out,
  output logic             cmp_zero_raw_out,
  output logic             cmp_one_raw_out,
  output logic             cmp_zero_reset_req,
  output logic             cmp_zero_irq,
  output logic             cmp_one_irq
);

  logic [1:0] on_q, rise_q, fall_q, rie_q, fie_q, rst_en_q;
  logic [1:0] hyp_q [2];
  logic [1:0] hyn_q [2];
  logic [1:0] pos_q [2];
  logic [1:0] neg_q [2];
  logic [1:0] resp_q [2];
  logic [1:0] sync1_q, sync2_q, prev_q;
  logic [1:0] core;
  logic       acc, wr;

  assign core = {cmp_one_core_out, cmp_zero_core_out};
  assign acc = psel && penable;
  assign wr  = acc && pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] base,
                               input int i);
    return a == base + 12'(i) * DCC_CMP_STRIDE;
  endfunction : hit

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_q <= 2'h0;
      rie_q <= 2'h0;
      fie_q <= 2'h0;
      rst_en_q <= 2'h0;
      for (int i = 0; i < 2; i++) begin
        hyp_q[i]  <= DCC_HYS_OFF;
        hyn_q[i]  <= DCC_HYS_OFF;
        pos_q[i]  <= DCC_FIELD_RST;
        neg_q[i]  <= DCC_FIELD_RST;
        resp_q[i] <= DCC_RESP_RST;
      end
    end else if (wr) begin
      if (paddr == DCC_ADDR_RSTSRC) begin
        rst_en_q <= pwdata[1:0];
      end
      for (int i = 0; i < 2; i++) begin
        if (hit(paddr, DCC_ADDR_CTRL0, i)) begin
          on_q[i]  <= pwdata[DCC_CTL_ON];
          hyp_q[i] <= pwdata[DCC_CTL_HYP_LO +: 2];
          hyn_q[i] <= pwdata[DCC_CTL_HYN_LO +: 2];
        end
        if (hit(paddr, DCC_ADDR_MUX0, i)) begin
          pos_q[i] <= pwdata[DCC_MX_POS_LO +: 2];
          neg_q[i] <= pwdata[DCC_MX_NEG_LO +: 2];
        end
        if (hit(paddr, DCC_ADDR_MODE0, i)) begin
          rie_q[i]  <= pwdata[DCC_MD_RIE];
          fie_q[i]  <= pwdata[DCC_MD_FIE];
          resp_q[i] <= pwdata[DCC_MD_RESP_LO +: 2];
        end
      end
    end
  end

  // Two-stage synchroniser; prev holds last seen synchronised level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
      prev_q  <= 2'h0;
    end else begin
      sync1_q <= core & on_q;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // Sticky edge flags; a detected edge beats a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_q <= 2'h0;
      fall_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (sync2_q[i] && !prev_q[i]) begin
          rise_q[i] <= 1'b1;
        end else if (wr && hit(paddr, DCC_ADDR_CTRL0, i)) begin
          rise_q[i] <= pwdata[DCC_CTL_RISE];
        end
        if (!sync2_q[i] && prev_q[i]) begin
          fall_q[i] <= 1'b1;
        end else if (wr && hit(paddr, DCC_ADDR_CTRL0, i)) begin
          fall_q[i] <= pwdata[DCC_CTL_FALL];
        end
      end
    end
  end

  // Read data is registered so the data output comes from flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0;
      if (paddr == DCC_ADDR_RSTSRC) begin
        prdata <= {30'h0, rst_en_q};
      end
      for (int i = 0; i < 2; i++) begin
        if (hit(paddr, DCC_ADDR_CTRL0, i)) begin
          prdata <= {24'h0, on_q[i], sync2_q[i], rise_q[i], fall_q[i],
                     hyp_q[i], hyn_q[i]};
        end
        if (hit(paddr, DCC_ADDR_MUX0, i)) begin
          prdata <= {24'h0, DCC_FIELD_RST, neg_q[i],
                     DCC_FIELD_RST, pos_q[i]};
        end
        if (hit(paddr, DCC_ADDR_MODE0, i)) begin
          prdata <= {24'h0, 2'h0, rie_q[i], fie_q[i], 2'h0, resp_q[i]};
        end
      end
    end
  end

  // Raw path has no flop so it keeps working with the clock stopped
  assign cmp_zero_raw_out = cmp_zero_core_out & on_q[0];
  assign cmp_one_raw_out  = cmp_one_core_out & on_q[1];
  assign cmp_zero_latched_out = sync2_q[0] & on_q[0];
  assign cmp_one_latched_out  = sync2_q[1] & on_q[1];
  assign cmp_zero_reset_req = rst_en_q[0] & on_q[0] & sync2_q[0];
  assign cmp_zero_irq = (rise_q[0] & rie_q[0])
                      | (fall_q[0] & fie_q[0]);
  assign cmp_one_irq  = (rise_q[1] & rie_q[1])
                      | (fall_q[1] & fie_q[1]);

  assign cmp_zero_on = on_q[0];
  assign cmp_one_on  = on_q[1];
  assign cmp_zero_pos_select = pos_q[0];
  assign cmp_zero_neg_select = neg_q[0];
  assign cmp_one_pos_select  = pos_q[1];
  assign cmp_one_neg_select  = neg_q[1];
  assign cmp_zero_pos_hysteresis = hyp_q[0];
  assign cmp_zero_neg_hysteresis = hyn_q[0];
  assign cmp_one_pos_hysteresis  = hyp_q[1];
  assign cmp_one_neg_hysteresis  = hyn_q[1];
  assign cmp_zero_response_select = resp_q[0];
  assign cmp_one_response_select  = resp_q[1];

  a_rise_sets: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(sync2_q[0]) |=> rise_q[0])
    else $error("rise flag missed");
  a_rise_sets_one: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(sync2_q[1]) |=> rise_q[1])
    else $error("rise flag missed");
  a_fall_sets: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(sync2_q[1]) |=> fall_q[1])
    else $error("fall flag missed");
  a_fall_sets_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(sync2_q[0]) |=> fall_q[0])
    else $error("fall flag missed");
  a_flag_sticky: assert property (
    @(posedge pclk) disable iff (!presetn)
    rise_q[0] && !wr |=> rise_q[0])
    else $error("flag dropped");
  a_fall_sticky: assert property (
    @(posedge pclk) disable iff (!presetn)
    fall_q[1] && !wr |=> fall_q[1])
    else $error("flag dropped");
  a_clear_by_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(rise_q[1]) || $fell(fall_q[0]) |-> $past(wr))
    else $error("flag cleared without a write");
  a_set_wins: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(sync2_q[1]) && wr |=> rise_q[1])
    else $error("clear won");
  a_irq_mask: assert property (
    @(posedge pclk) disable iff (!presetn)
    cmp_zero_irq |-> (rise_q[0] && rie_q[0]) || (fall_q[0] && fie_q[0]))
    else $error("irq without enabled flag");
  a_irq_rise: assert property (
    @(posedge pclk) disable iff (!presetn)
    rise_q[1] && rie_q[1] |-> cmp_one_irq)
    else $error("enabled rise flag without irq");
  a_irq_fall: assert property (
    @(posedge pclk) disable iff (!presetn)
    fall_q[1] && fie_q[1] |-> cmp_one_irq)
    else $error("enabled fall flag without irq");
  a_irq_quiet: assert property (
    @(posedge pclk) disable iff (!presetn)
    !rie_q[0] && !fie_q[0] |-> !cmp_zero_irq)
    else $error("masked irq raised");
  a_off_low: assert property (
    @(posedge pclk) disable iff (!presetn)
    !on_q[1] |-> !cmp_one_latched_out && !cmp_one_raw_out)
    else $error("disabled output high");
  a_off_low_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    !on_q[0] |-> !cmp_zero_latched_out && !cmp_zero_raw_out
    && !cmp_zero_reset_req)
    else $error("disabled output high");
  a_raw_follows: assert property (
    @(posedge pclk) disable iff (!presetn)
    cmp_zero_raw_out == (cmp_zero_core_out && cmp_zero_on))
    else $error("raw output wrong");
  a_sync_delay: assert property (
    @(posedge pclk) disable iff (!presetn)
    on_q[0] && core[0] ##1 on_q[0] |=> sync2_q[0])
    else $error("sync latency wrong");
  a_latched_lag: assert property (
    @(posedge pclk) disable iff (!presetn)
    cmp_one_latched_out |-> $past(cmp_one_core_out, 2))
    else $error("latched output ahead of core");
  a_result_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == DCC_ADDR_CTRL1
    |=> prdata[DCC_CTL_RESULT] == $past(sync2_q[1]))
    else $error("result bit not current");
  a_reset_req: assert property (
    @(posedge pclk) disable iff (!presetn)
    cmp_zero_reset_req |-> rst_en_q[0] && cmp_zero_latched_out)
    else $error("reset request unqualified");
  a_reset_src: assert property (
    @(posedge pclk) disable iff (!presetn)
    rst_en_q[0] && cmp_zero_latched_out |-> cmp_zero_reset_req)
    else $error("reset request missing");
  a_on_written: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr && paddr == DCC_ADDR_CTRL0
    |=> cmp_zero_on == $past(pwdata[DCC_CTL_ON]))
    else $error("enable not applied");
  a_hys_passed: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr && paddr == DCC_ADDR_CTRL1
    |=> cmp_one_pos_hysteresis == $past(pwdata[DCC_CTL_HYP_LO +: 2])
    && cmp_one_neg_hysteresis == $past(pwdata[DCC_CTL_HYN_LO +: 2]))
    else $error("hysteresis not applied");
  a_resp_passed: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr && paddr == DCC_ADDR_MODE0
    |=> cmp_zero_response_select == $past(pwdata[DCC_MD_RESP_LO +: 2]))
    else $error("response time not applied");
  a_sel_passed: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr && paddr == DCC_ADDR_MUX1
    |=> cmp_one_pos_select == $past(pwdata[DCC_MX_POS_LO +: 2])
    && cmp_one_neg_select == $past(pwdata[DCC_MX_NEG_LO +: 2]))
    else $error("input select not applied");
  a_mux_unused: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == DCC_ADDR_MUX0
    |=> prdata[DCC_MX_NEG_LO + 2 +: 2] == DCC_FIELD_RST
    && prdata[DCC_MX_POS_LO + 2 +: 2] == DCC_FIELD_RST)
    else $error("unused mux bits not one");
  c_rise_irq: cover property (@(posedge pclk) cmp_zero_irq && rie_q[0]);
  c_fall_irq: cover property (@(posedge pclk) cmp_one_irq && fie_q[1]);
  c_reset_req: cover property (@(posedge pclk) cmp_zero_reset_req);
  c_fall_flag: cover property (@(posedge pclk) $rose(fall_q[0]));
  c_flag_clear: cover property (@(posedge pclk) $fell(rise_q[1]));
endmodule : dcc_top
`default_nettype wire

// *** test/dcc_core_model.sv ***
// Behavioural model of the two analog comparator cores
`default_nettype none
module dcc_core_model (
  // Core results
  output var logic core0,
  output var logic core1
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    core0 = 1'h0;
    core1 = 1'h0;
  end
  // Results move off the clock edge, as an analog core would
  task automatic settle(input logic v0, input logic v1, input int dly);
    #(dly);
    core0 = v0;
    core1 = v1;
  endtask : settle
endmodule : dcc_core_model
`default_nettype wire

// *** test/dcc_top_tb.sv ***
// Self-checking bench for the comparator control block
`default_nettype none
module dcc_top_tb
  import dcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, seed = 32'hDD9FAD20;
  logic        pready, pslverr, cmp_zero_core_out, cmp_one_core_out;
  logic        cmp_zero_on, cmp_one_on, cmp_zero_reset_req;
  logic        cmp_zero_latched_out, cmp_one_latched_out, cmp_zero_irq;
  logic        cmp_zero_raw_out, cmp_one_raw_out, cmp_one_irq;
  logic [1:0]  cmp_zero_pos_select, cmp_zero_neg_select;
  logic [1:0]  cmp_one_pos_select, cmp_one_neg_select;
  logic [1:0]  cmp_zero_pos_hysteresis, cmp_zero_neg_hysteresis;
  logic [1:0]  cmp_one_pos_hysteresis, cmp_one_neg_hysteresis;
  logic [1:0]  cmp_zero_response_select, cmp_one_response_select;
  logic [31:0] exp_q[$];
  logic [31:0] obs_q[$];
  event        obs_ev;
  int          bad_count = 0;
  int          n_checks = 0;
  always #2.5 pclk = ~pclk;
  dcc_core_model i_core (.core0(cmp_zero_core_out), .core1(cmp_one_core_out));
  dcc_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .cmp_zero_core_out, .cmp_one_core_out,
    .cmp_zero_on, .cmp_one_on, .cmp_zero_pos_select, .cmp_zero_neg_select,
    .cmp_one_pos_select, .cmp_one_neg_select, .cmp_zero_pos_hysteresis,
    .cmp_zero_neg_hysteresis, .cmp_one_pos_hysteresis,
    .cmp_one_neg_hysteresis, .cmp_zero_response_select,
    .cmp_one_response_select, .cmp_zero_latched_out, .cmp_one_latched_out,
    .cmp_zero_raw_out, .cmp_one_raw_out, .cmp_zero_reset_req,
    .cmp_zero_irq, .cmp_one_irq);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [31:0] outs(input int i);
    return i ? {21'h0, cmp_one_on, cmp_one_pos_select, cmp_one_neg_select,
      cmp_one_pos_hysteresis, cmp_one_neg_hysteresis,
      cmp_one_response_select} : {21'h0, cmp_zero_on, cmp_zero_pos_select,
      cmp_zero_neg_select, cmp_zero_pos_hysteresis, cmp_zero_neg_hysteresis,
      cmp_zero_response_select};
  endfunction : outs
  function automatic logic [31:0] pins(input int i);
    return i ? {28'h0, cmp_one_raw_out, cmp_one_latched_out, cmp_one_irq,
      cmp_zero_reset_req} : {28'h0, cmp_zero_raw_out, cmp_zero_latched_out,
      cmp_zero_irq, cmp_zero_reset_req};
  endfunction : pins
  task automatic report_and_stop();
    // One edge lets the compare process drain its queue first
    @(posedge pclk);
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    exp_q.push_back(exp);
    obs_q.push_back(act);
    ->obs_ev;
  endtask : chk
  // Several results may land in one time step, so drain them all
  always @(obs_ev) begin
    logic [31:0] e;
    logic [31:0] a;
    while (exp_q.size() > 0 && obs_q.size() > 0) begin
      e = exp_q.pop_front();
      a = obs_q.pop_front();
      n_checks++;
      if (a !== e) begin
        bad_count++;
        $display("wrong value at %0t: got %h expected %h", $time, a, e);
      end
    end
  end
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    int n;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      report_and_stop();
    end
    q = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    apb(1'h1, a, d, q);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'h0, a, 8'h0, q);
    chk(q, e);
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  initial begin
    logic [31:0] r;
    logic [7:0]  c;
    logic [11:0] b;
    cyc(10);
    presetn <= 1'h1;
    cyc(1);
    for (int i = 0; i < 2; i++) begin
      b = i ? DCC_CMP_STRIDE : 12'h000;
      rd(DCC_ADDR_CTRL0 + b, 32'h00);
      rd(DCC_ADDR_MUX0 + b, 32'hFF);
      rd(DCC_ADDR_MODE0 + b, 32'h02);
      chk(outs(i), 32'h3C2);
    end
    rd(12'h030, 32'h0);
    $display("test reset values done");
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 2; i++) begin
        b = i ? DCC_CMP_STRIDE : 12'h000;
        r = rnd();
        c = {r[7], 3'h0, 2'(k), 2'(3 - k)};
        wr(DCC_ADDR_CTRL0 + b, c);
        wr(DCC_ADDR_MUX0 + b, r[15:8]);
        wr(DCC_ADDR_MODE0 + b, {r[23:18], 2'(k)});
        rd(DCC_ADDR_CTRL0 + b, {24'h0, c});
        rd(DCC_ADDR_MUX0 + b, {24'h0, r[15:8] | 8'hCC});
        rd(DCC_ADDR_MODE0 + b, {24'h0, 2'h0, r[21:20], 2'h0, 2'(k)});
        chk(outs(i), {21'h0, c[7], r[9:8], r[13:12], c[3:0], 2'(k)});
      end
    end
    $display("test field routing done");
    wr(DCC_ADDR_RSTSRC, 8'h01);
    for (int i = 0; i < 2; i++) begin
      b = i ? DCC_CMP_STRIDE : 12'h000;
      wr(DCC_ADDR_MODE0 + b, 8'h22);
      wr(DCC_ADDR_CTRL0 + b, 8'h80);
      cyc(4);
      wr(DCC_ADDR_CTRL0 + b, 8'h80);
      i_core.settle(i == 0, i == 1, 2);
      #1;
      chk(pins(i), 32'h8);
      cyc(4);
      chk(pins(i), {31'h7, i == 0});
      rd(DCC_ADDR_CTRL0 + b, 32'hE0);
      i_core.settle(1'h0, 1'h0, 2);
      cyc(4);
      chk(pins(i), 32'h2);
      rd(DCC_ADDR_CTRL0 + b, 32'hB0);
      cyc(8);
      wr(DCC_ADDR_CTRL0 + b, 8'hA0);
      rd(DCC_ADDR_CTRL0 + b, 32'hA0);
      wr(DCC_ADDR_MODE0 + b, 8'h12);
      chk(pins(i), 32'h0);
      wr(DCC_ADDR_CTRL0 + b, 8'h90);
      chk(pins(i), 32'h2);
      wr(DCC_ADDR_MODE0 + b, 8'h02);
      i_core.settle(i == 0, i == 1, 2);
      cyc(4);
      wr(DCC_ADDR_CTRL0 + b, 8'h00);
      chk(pins(i), 32'h0);
      i_core.settle(1'h0, 1'h0, 2);
      cyc(4);
    end
    $display("test edges and outputs done");
    presetn <= 1'h0;
    cyc(3);
    presetn <= 1'h1;
    cyc(1);
    rd(DCC_ADDR_CTRL1, 32'h00);
    rd(DCC_ADDR_MODE1, 32'h02);
    rd(DCC_ADDR_MUX1, 32'hFF);
    chk(pins(1), 32'h0);
    $display("test second reset done");
    report_and_stop();
  end
endmodule : dcc_top_tb
`default_nettype wire
